// >>> rtl/mmd_decode.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1: Separate 8 kB SRAM and 64 kB flash regions.
// RULE2: Top 2 kB flash boot page is unreachable.
// RULE3: Reset mirrors flash at address zero.
// RULE4: Remap bit chooses SRAM or flash mirror.
// RULE5: One flat 32-bit byte address space.
// RULE6: Multi-byte data is little endian.
// RULE7: Flash is 32k halfwords, 512-byte pages.
// RULE8: Word flash access takes two halfword reads.
// RULE9: Flash access paced to its maximum rate.
// RULE10: SRAM is 2k words, one access per word.
// RULE11: Register space fills the two top pages.
// RULE12: All peripheral registers decoded in that space.
// RULE13: Software avoids unoccupied register locations.
// RULE14: Fast bus one cycle, peripheral bus two.
// RULE15: Flash, port and PWM registers use fast bus.
// RULE16: Unoccupied register accesses read zero, no effect.
module mmd_decode (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic remap_sram_i,
    input wire logic core_req_i,
    input wire logic [mmd_pkg::ADDR_W-1:0] core_addr_i,
    input wire logic core_we_i,
    input wire logic [1:0] core_size_i,
    input wire logic [mmd_pkg::DATA_W-1:0] core_wdata_i,
    output logic core_busy_o,
    output logic core_ready_o,
    output logic [mmd_pkg::DATA_W-1:0] core_rdata_o,
    output logic remap_sram_o,
    output logic sb_sel_o,
    output logic sb_we_o,
    output logic [mmd_pkg::ADDR_W-1:0] sb_addr_o,
    output logic [mmd_pkg::DATA_W-1:0] sb_wdata_o,
    output logic [3:0] sb_be_o,
    input wire logic [mmd_pkg::DATA_W-1:0] sb_rdata_i,
    output logic pb_sel_o,
    output logic pb_enable_o,
    output logic pb_we_o,
    output logic [mmd_pkg::ADDR_W-1:0] pb_addr_o,
    output logic [mmd_pkg::DATA_W-1:0] pb_wdata_o,
    output logic [3:0] pb_be_o,
    input wire logic [mmd_pkg::DATA_W-1:0] pb_rdata_i
);
    import mmd_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_FL_LO, ST_FL_HI, ST_SB, ST_PB_SET, ST_PB_EN
    } mmd_state_t;

    mmd_state_t state_r, state_nxt;
    logic busy_r, busy_nxt;
    logic ready_r, ready_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic remap_r, remap_nxt;
    logic [31:0] addr_r, addr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] be_r, be_nxt;
    logic we_r, we_nxt;
    logic word_r, word_nxt;
    logic [FLASH_AW-1:0] fl_addr_r, fl_addr_nxt;
    logic fl_req_r, fl_req_nxt;
    logic sb_sel_r, sb_sel_nxt;
    logic pb_sel_r, pb_sel_nxt;
    logic pb_en_r, pb_en_nxt;

    logic [31:0] sram [SRAM_WORDS];
    logic [3:0] be_in;
    logic [31:0] fl_off, sr_off;
    logic hit_alias, hit_fl, hit_sr, hit_boot, hit_mrs, hit_sb, hit_pb;
    logic sram_wr;
    logic [SRAM_AW-1:0] sram_idx;

    mmd_flash_if #(.AW(FLASH_AW), .DW(FLASH_DW)) fl_bus ();

    // Flash array behind the halfword sequencer.
    mmd_flash_bank #(
        .WORDS(FLASH_WORDS),
        .AW(FLASH_AW),
        .ACC_CYC(FLASH_ACC_CYC)
    ) u_flash (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .fl(fl_bus.bank)
    );

    // Byte lanes from size and low address bits.
    always_comb begin
        // RULE6 little endian lanes
        case (core_size_i)
            SZ_BYTE: be_in = 4'h1 << core_addr_i[1:0];
            SZ_HALF: be_in = core_addr_i[1] ? 4'hC : 4'h3;
            default: be_in = 4'hF;
        endcase
    end

    // Region decode of the incoming address.
    always_comb begin
        // RULE5 flat address decode
        hit_alias = core_addr_i < ALIAS_BYTES;
        // RULE3 flash mirrored unless remapped
        fl_off = hit_alias ? core_addr_i : core_addr_i - FLASH_BASE;
        sr_off = hit_alias ? core_addr_i : core_addr_i - SRAM_BASE;
        // RULE1 fixed memory regions
        // RULE4 remap picks SRAM mirror
        hit_fl = hit_alias ? !remap_r
                 : (core_addr_i >= FLASH_BASE
                    && core_addr_i < FLASH_BASE + FLASH_BYTES);
        hit_sr = (hit_alias ? remap_r
                  : core_addr_i >= SRAM_BASE)
                 && sr_off < SRAM_BYTES;
        // RULE2 boot page hidden
        hit_boot = hit_fl && fl_off >= (FLASH_BYTES - FLASH_BOOT_BYTES);
        // RULE11 top two pages
        hit_mrs = core_addr_i >= MRS_BASE;
        // RULE12 register decode
        // RULE15 fast bus blocks
        hit_sb = hit_mrs
                 && (core_addr_i[31:SB_WIN_LSB] == SB_GPIO_BASE[31:SB_WIN_LSB]
                 || core_addr_i[31:SB_WIN_LSB] == SB_FLCTL_BASE[31:SB_WIN_LSB]
                 || core_addr_i[31:SB_WIN_LSB] == SB_PWM_BASE[31:SB_WIN_LSB]);
        hit_pb = hit_mrs
                 && core_addr_i[31:PB_WIN_LSB] == PB_BASE[31:PB_WIN_LSB];
        sram_idx = sr_off[SRAM_AW+1:2];
    end

    // Main sequencer: decode, access, answer.
    always_comb begin
        state_nxt = state_r;
        busy_nxt = busy_r;
        ready_nxt = 1'b0;
        rdata_nxt = rdata_r;
        remap_nxt = remap_sram_i;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        be_nxt = be_r;
        we_nxt = we_r;
        word_nxt = word_r;
        fl_addr_nxt = fl_addr_r;
        fl_req_nxt = 1'b0;
        sb_sel_nxt = 1'b0;
        pb_sel_nxt = pb_sel_r;
        pb_en_nxt = pb_en_r;
        sram_wr = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (core_req_i) begin
                    addr_nxt = core_addr_i;
                    wdata_nxt = core_wdata_i;
                    be_nxt = be_in;
                    we_nxt = core_we_i;
                    if (hit_sr) begin
                        // RULE10 single SRAM access
                        sram_wr = core_we_i;
                        rdata_nxt = core_we_i ? 32'h0000_0000
                                    : sram[sram_idx];
                        ready_nxt = 1'b1;
                    end else if (hit_fl && !hit_boot) begin
                        // RULE7 halfword flash array
                        // RULE8 word needs two halfwords
                        word_nxt = core_size_i == SZ_WORD;
                        fl_addr_nxt = core_size_i == SZ_WORD
                                      ? {fl_off[15:2], 1'b0}
                                      : fl_off[15:1];
                        fl_req_nxt = 1'b1;
                        rdata_nxt = 32'h0000_0000;
                        busy_nxt = 1'b1;
                        state_nxt = ST_FL_LO;
                    end else if (hit_sb) begin
                        sb_sel_nxt = 1'b1;
                        busy_nxt = 1'b1;
                        state_nxt = ST_SB;
                    end else if (hit_pb) begin
                        pb_sel_nxt = 1'b1;
                        busy_nxt = 1'b1;
                        state_nxt = ST_PB_SET;
                    end else begin
                        // RULE16 unoccupied reads zero
                        rdata_nxt = 32'h0000_0000;
                        ready_nxt = 1'b1;
                    end
                end
            end
            ST_FL_LO: begin
                // RULE9 paced flash access
                if (fl_bus.done) begin
                    if (word_r) begin
                        rdata_nxt[15:0] = fl_bus.rdata;
                        fl_addr_nxt = fl_addr_r + 15'h0001;
                        fl_req_nxt = 1'b1;
                        state_nxt = ST_FL_HI;
                    end else begin
                        rdata_nxt = we_r ? 32'h0000_0000
                                    : {2{fl_bus.rdata}};
                        ready_nxt = 1'b1;
                        busy_nxt = 1'b0;
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_FL_HI: begin
                if (fl_bus.done) begin
                    rdata_nxt[31:16] = we_r ? 16'h0000 : fl_bus.rdata;
                    if (we_r) begin
                        rdata_nxt[15:0] = 16'h0000;
                    end
                    ready_nxt = 1'b1;
                    busy_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            ST_SB: begin
                // RULE14 fast bus one cycle
                rdata_nxt = we_r ? 32'h0000_0000 : sb_rdata_i;
                ready_nxt = 1'b1;
                busy_nxt = 1'b0;
                state_nxt = ST_IDLE;
            end
            ST_PB_SET: begin
                pb_en_nxt = 1'b1;
                state_nxt = ST_PB_EN;
            end
            ST_PB_EN: begin
                // RULE14 peripheral bus two cycles
                rdata_nxt = we_r ? 32'h0000_0000 : pb_rdata_i;
                pb_sel_nxt = 1'b0;
                pb_en_nxt = 1'b0;
                ready_nxt = 1'b1;
                busy_nxt = 1'b0;
                state_nxt = ST_IDLE;
            end
            default: begin
                busy_nxt = 1'b0;
                pb_sel_nxt = 1'b0;
                pb_en_nxt = 1'b0;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers; reset restores the flash mirror.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
            ready_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            // RULE3 reset selects flash
            remap_r <= 1'b0;
            addr_r <= 32'h0000_0000;
            wdata_r <= 32'h0000_0000;
            be_r <= 4'h0;
            we_r <= 1'b0;
            word_r <= 1'b0;
            fl_addr_r <= '0;
            fl_req_r <= 1'b0;
            sb_sel_r <= 1'b0;
            pb_sel_r <= 1'b0;
            pb_en_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            busy_r <= busy_nxt;
            ready_r <= ready_nxt;
            rdata_r <= rdata_nxt;
            remap_r <= remap_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            be_r <= be_nxt;
            we_r <= we_nxt;
            word_r <= word_nxt;
            fl_addr_r <= fl_addr_nxt;
            fl_req_r <= fl_req_nxt;
            sb_sel_r <= sb_sel_nxt;
            pb_sel_r <= pb_sel_nxt;
            pb_en_r <= pb_en_nxt;
        end
    end

    // SRAM byte writes, little endian lanes.
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (sram_wr && be_in[i]) begin
                sram[sram_idx][8*i +: 8] <= core_wdata_i[8*i +: 8];
            end
        end
    end

    // Flash request; lanes follow the halfword bit.
    assign fl_bus.req = fl_req_r;
    assign fl_bus.we = we_r;
    assign fl_bus.addr = fl_addr_r;
    assign fl_bus.wdata = fl_addr_r[0] ? wdata_r[31:16] : wdata_r[15:0];
    assign fl_bus.be = fl_addr_r[0] ? be_r[3:2] : be_r[1:0];

    // Outputs, all from registers.
    assign core_busy_o = busy_r;
    assign core_ready_o = ready_r;
    assign core_rdata_o = rdata_r;
    assign remap_sram_o = remap_r;
    assign sb_sel_o = sb_sel_r;
    assign sb_we_o = we_r;
    assign sb_addr_o = addr_r;
    assign sb_wdata_o = wdata_r;
    assign sb_be_o = be_r;
    assign pb_sel_o = pb_sel_r;
    assign pb_enable_o = pb_en_r;
    assign pb_we_o = we_r;
    assign pb_addr_o = addr_r;
    assign pb_wdata_o = wdata_r;
    assign pb_be_o = be_r;
endmodule : mmd_decode

// >>> rtl/mmd_flash_bank.sv
`timescale 1ns/1ps
module mmd_flash_bank #(
    parameter int WORDS = mmd_pkg::FLASH_WORDS,
    parameter int AW = mmd_pkg::FLASH_AW,
    parameter int ACC_CYC = mmd_pkg::FLASH_ACC_CYC
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    mmd_flash_if.bank fl
);
    import mmd_pkg::*;

    logic [15:0] mem [WORDS];
    logic [7:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic we_r, we_nxt;
    logic [AW-1:0] addr_r, addr_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic [1:0] be_r, be_nxt;

    // Done pulses ACC_CYC cycles after the request register rises.
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        rdata_nxt = rdata_r;
        we_nxt = we_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        be_nxt = be_r;
        if (!busy_r && fl.req) begin
            busy_nxt = 1'b1;
            cnt_nxt = 8'(ACC_CYC - 2);
            we_nxt = fl.we;
            addr_nxt = fl.addr;
            wdata_nxt = fl.wdata;
            be_nxt = fl.be;
        end else if (busy_r) begin
            if (cnt_r == 8'h00) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                rdata_nxt = mem[addr_r];
            end else begin
                cnt_nxt = cnt_r - 8'h01;
            end
        end
    end

    // Registers of the access sequencer.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_r <= 8'h00;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= 16'h0000;
            we_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= 16'h0000;
            be_r <= 2'h0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            rdata_r <= rdata_nxt;
            we_r <= we_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            be_r <= be_nxt;
        end
    end

    // A halfword write lands as the access completes.
    always_ff @(posedge sys_clk_i) begin
        if (busy_r && cnt_r == 8'h00 && we_r) begin
            if (be_r[0]) begin
                mem[addr_r][7:0] <= wdata_r[7:0];
            end
            if (be_r[1]) begin
                mem[addr_r][15:8] <= wdata_r[15:8];
            end
        end
    end

    assign fl.done = done_r;
    assign fl.rdata = rdata_r;
endmodule : mmd_flash_bank

// >>> rtl/mmd_flash_if.sv
`timescale 1ns/1ps
interface mmd_flash_if #(parameter int AW = 15, parameter int DW = 16);
    logic req;
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW/8-1:0] be;
    logic done;
    logic [DW-1:0] rdata;
    modport ctl (output req, output we, output addr, output wdata,
                 output be, input done, input rdata);
    modport bank (input req, input we, input addr, input wdata,
                  input be, output done, output rdata);
endinterface : mmd_flash_if

// >>> rtl/mmd_pkg.sv
package mmd_pkg;
    // Core address and data widths.
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    // Access size codes on core_size_i.
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    // Physical placement of the two memories.
    localparam logic [31:0] FLASH_BASE = 32'h0008_0000;
    localparam logic [31:0] FLASH_BYTES = 32'h0001_0000;
    localparam logic [31:0] FLASH_BOOT_BYTES = 32'h0000_0800;
    localparam logic [31:0] FLASH_PAGE_BYTES = 32'h0000_0200;
    localparam int FLASH_WORDS = 32768;
    localparam int FLASH_AW = 15;
    localparam int FLASH_DW = 16;
    localparam logic [31:0] SRAM_BASE = 32'h0001_0000;
    localparam logic [31:0] SRAM_BYTES = 32'h0000_2000;
    localparam int SRAM_WORDS = 2048;
    localparam int SRAM_AW = 11;
    // Window at the bottom of the map that mirrors flash or SRAM.
    localparam logic [31:0] ALIAS_BYTES = 32'h0001_0000;
    // Mapped register space: the two uppermost pages.
    localparam logic [31:0] MRS_BASE = 32'hFFFF_0000;
    // Fast system bus windows, 1 kB each.
    localparam logic [31:0] SB_GPIO_BASE = 32'hFFFF_F400;
    localparam logic [31:0] SB_FLCTL_BASE = 32'hFFFF_F800;
    localparam logic [31:0] SB_PWM_BASE = 32'hFFFF_FC00;
    localparam int SB_WIN_LSB = 10;
    // Peripheral bus window, 4 kB.
    localparam logic [31:0] PB_BASE = 32'hFFFF_0000;
    localparam int PB_WIN_LSB = 12;
    // Timing of one 16-bit flash access.
    localparam int CLK_PS = 4000;
    localparam int FLASH_MAX_KHZ = 41780;
    localparam int FLASH_ACC_PS = (1000000000 + FLASH_MAX_KHZ - 1)
                                  / FLASH_MAX_KHZ;
    localparam int FLASH_ACC_CYC = (FLASH_ACC_PS + CLK_PS - 1) / CLK_PS;
endpackage : mmd_pkg

// >>> verification/mmd_bus_partner.sv
`timescale 1ns/1ps
module mmd_bus_partner (
    input wire logic sys_clk_i,
    input wire logic sb_sel_i,
    input wire logic [31:0] sb_addr_i,
    input wire logic pb_sel_i,
    input wire logic pb_enable_i,
    input wire logic [31:0] pb_addr_i,
    output logic [31:0] sb_rdata_o,
    output logic [31:0] pb_rdata_o
);
    logic [31:0] noise_r = 32'h0000_0001;

    // Idle read lines carry a moving pattern.
    always @(posedge sys_clk_i) begin
        noise_r <= {noise_r[30:0], noise_r[31] ^ noise_r[21]} ^ 32'h0000_0100;
    end

    assign sb_rdata_o = sb_sel_i ? (sb_addr_i ^ 32'h5A5A_0000) : noise_r;

    assign pb_rdata_o = (pb_sel_i && pb_enable_i) ?
                        (pb_addr_i ^ 32'hC3C3_0000) : ~noise_r;
endmodule : mmd_bus_partner

// >>> verification/mmd_decode_asserts.sv
`timescale 1ns/1ps
module mmd_decode_asserts
    import mmd_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic core_req_i,
    input wire logic [31:0] core_addr_i,
    input wire logic core_we_i,
    input wire logic [1:0] core_size_i,
    input wire logic core_busy_o,
    input wire logic core_ready_o,
    input wire logic [31:0] core_rdata_o,
    input wire logic remap_sram_o,
    input wire logic sb_sel_o,
    input wire logic [31:0] sb_addr_o,
    input wire logic [3:0] sb_be_o,
    input wire logic pb_sel_o,
    input wire logic pb_enable_o,
    input wire logic [31:0] pb_addr_o
);
    logic take, in_flash, in_boot, in_sram, in_sb, in_pb, in_hole;
    logic [1:0] lane;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Classify the address being taken.
    assign take = core_req_i && !core_busy_o;
    assign lane = core_addr_i[1:0];
    assign in_flash = core_addr_i[31:16] == FLASH_BASE[31:16];
    assign in_boot = in_flash && core_addr_i[15:11] == 5'h1F;
    assign in_sram = core_addr_i[31:13] == SRAM_BASE[31:13];
    assign in_sb = core_addr_i[31:12] == 20'hF_FFFF
                   && core_addr_i[11:10] != 2'h0;
    assign in_pb = core_addr_i[31:12] == PB_BASE[31:12];
    assign in_hole = core_addr_i[31:16] == MRS_BASE[31:16] && !in_sb && !in_pb;

    // Peripheral access: setup, enable, answer.
    sequence pb_setup;
        pb_sel_o && !pb_enable_o;
    endsequence
    sequence pb_access;
        pb_setup ##1 pb_sel_o && pb_enable_o ##1 !pb_sel_o && core_ready_o;
    endsequence

    a_sb_one_cycle: assert property (
        take && in_sb |=> sb_sel_o ##1 !sb_sel_o && core_ready_o)
        else $error("fast bus late");
    a_pb_two_cycle: assert property (
        take && in_pb |=> pb_access)
        else $error("peripheral bus late");
    a_sb_window: assert property (
        sb_sel_o |-> sb_addr_o[31:12] == 20'hF_FFFF && sb_addr_o[11:10] != 0)
        else $error("fast bus off window");
    a_pb_window: assert property (
        pb_sel_o |-> pb_addr_o[31:12] == PB_BASE[31:12] && !sb_sel_o)
        else $error("peripheral bus off window");
    a_sb_lanes: assert property (
        take && in_sb && core_size_i == SZ_BYTE
        |=> sb_be_o == (4'h1 << $past(lane)))
        else $error("bad byte enable");
    a_sram_fast: assert property (
        take && in_sram |=> core_ready_o && !core_busy_o)
        else $error("SRAM late");
    a_flash_word: assert property (
        take && in_flash && !in_boot && !core_we_i && core_size_i == SZ_WORD
        |=> core_busy_o ##13 !core_ready_o ##1 core_ready_o)
        else $error("flash word late");
    a_flash_half: assert property (
        take && in_flash && !in_boot && !core_we_i && core_size_i != SZ_WORD
        |=> core_busy_o ##6 !core_ready_o ##1 core_ready_o)
        else $error("flash half late");
    a_boot_hidden: assert property (
        take && in_boot && !core_we_i |=> core_ready_o && core_rdata_o == '0)
        else $error("boot page visible");
    a_hole_zero: assert property (
        take && in_hole
        |=> core_ready_o && core_rdata_o == '0 && !sb_sel_o && !pb_sel_o)
        else $error("hole had effect");
    a_reset_flash: assert property (
        $past(sys_rst_i) |-> !remap_sram_o && !core_busy_o && !core_ready_o)
        else $error("not idle after reset");
endmodule : mmd_decode_asserts

bind mmd_decode mmd_decode_asserts u_chk (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .core_req_i(core_req_i),
    .core_addr_i(core_addr_i), .core_we_i(core_we_i),
    .core_size_i(core_size_i), .core_busy_o(core_busy_o),
    .core_ready_o(core_ready_o), .core_rdata_o(core_rdata_o),
    .remap_sram_o(remap_sram_o), .sb_sel_o(sb_sel_o),
    .sb_addr_o(sb_addr_o), .sb_be_o(sb_be_o), .pb_sel_o(pb_sel_o),
    .pb_enable_o(pb_enable_o), .pb_addr_o(pb_addr_o)
);

// >>> verification/test_memory_map_bus_decode.sv
`timescale 1ns/1ps
module test_memory_map_bus_decode;
    import mmd_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic remap_sram_i = 1'b0;
    logic core_req_i = 1'b0;
    logic [31:0] core_addr_i = 32'h0000_0000;
    logic core_we_i = 1'b0;
    logic [1:0] core_size_i = 2'h0;
    logic [31:0] core_wdata_i = 32'h0000_0000;
    logic core_busy_o, core_ready_o, remap_sram_o;
    logic sb_sel_o, sb_we_o, pb_sel_o, pb_enable_o, pb_we_o;
    logic [31:0] core_rdata_o, sb_addr_o, sb_wdata_o, sb_rdata_i;
    logic [31:0] pb_addr_o, pb_wdata_o, pb_rdata_i;
    logic [3:0] sb_be_o, pb_be_o;
    logic [31:0] exp_d[$];
    logic [31:0] exp_m[$];
    logic [31:0] seed = 32'h0000_cfe8;
    logic [31:0] ra, mk, ed;
    logic [31:0] hole[4] = '{32'hFFFF_1000, 32'hFFFF_F000, 32'hFFFF_F3FC,
                             32'h0040_0000};
    int n_errors = 0;
    int total_checks = 0;

    mmd_decode dut (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .remap_sram_i(remap_sram_i), .core_req_i(core_req_i),
        .core_addr_i(core_addr_i), .core_we_i(core_we_i),
        .core_size_i(core_size_i), .core_wdata_i(core_wdata_i),
        .core_busy_o(core_busy_o), .core_ready_o(core_ready_o),
        .core_rdata_o(core_rdata_o), .remap_sram_o(remap_sram_o),
        .sb_sel_o(sb_sel_o), .sb_we_o(sb_we_o), .sb_addr_o(sb_addr_o),
        .sb_wdata_o(sb_wdata_o), .sb_be_o(sb_be_o), .sb_rdata_i(sb_rdata_i),
        .pb_sel_o(pb_sel_o), .pb_enable_o(pb_enable_o), .pb_we_o(pb_we_o),
        .pb_addr_o(pb_addr_o), .pb_wdata_o(pb_wdata_o), .pb_be_o(pb_be_o),
        .pb_rdata_i(pb_rdata_i)
    );

    mmd_bus_partner u_bus (
        .sys_clk_i(sys_clk_i), .sb_sel_i(sb_sel_o), .sb_addr_i(sb_addr_o),
        .pb_sel_i(pb_sel_o), .pb_enable_i(pb_enable_o),
        .pb_addr_i(pb_addr_o), .sb_rdata_o(sb_rdata_i),
        .pb_rdata_o(pb_rdata_i)
    );

    // Free-running core clock.
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // One access: note the expectation, request, count edges.
    task automatic acc(input logic [31:0] a, input logic we,
                       input logic [1:0] sz, input logic [31:0] wd,
                       input logic [31:0] e, input logic [31:0] m,
                       input int lat);
        int cnt;
        cnt = 0;
        exp_d.push_back(e);
        exp_m.push_back(m);
        @(posedge sys_clk_i);
        core_req_i <= 1'b1;
        core_addr_i <= a;
        core_we_i <= we;
        core_size_i <= sz;
        core_wdata_i <= wd;
        @(posedge sys_clk_i);
        core_req_i <= 1'b0;
        do begin
            @(posedge sys_clk_i);
            cnt++;
        end while (core_ready_o !== 1'b1 && cnt < 40);
        check(32'(cnt), 32'(lat));
    endtask : acc

    // Writes answer with zero read data.
    task automatic wr(input logic [31:0] a, input logic [1:0] sz,
                      input logic [31:0] wd, input int lat);
        acc(a, 1'b1, sz, wd, 32'h0000_0000, 32'hFFFF_FFFF, lat);
    endtask : wr

    task automatic rdc(input logic [31:0] a, input logic [1:0] sz,
                       input logic [31:0] e, input int lat,
                       input logic [31:0] m = 32'hFFFF_FFFF);
        acc(a, 1'b0, sz, 32'h0000_0000, e, m, lat);
    endtask : rdc

    // Each answer meets the oldest note on its valid lanes.
    always @(posedge sys_clk_i) begin
        if (core_ready_o === 1'b1) begin
            mk = (exp_m.size() != 0) ? exp_m.pop_front() : 32'hFFFF_FFFF;
            ed = (exp_d.size() != 0) ? exp_d.pop_front() : ~core_rdata_o;
            check(core_rdata_o & mk, ed & mk);
        end
    end

    // Watchdog far past the expected run.
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        check({29'h0000_0000, core_busy_o, core_ready_o, remap_sram_o},
              32'h0000_0000);
        // Byte and halfword lanes of one SRAM word.
        wr(SRAM_BASE + 32'h0000_0010, SZ_WORD, 32'h1122_3344, 1);
        for (int k = 0; k < 4; k++) begin
            rdc(SRAM_BASE + 32'h0000_0010 + k, SZ_BYTE, 32'h1122_3344, 1,
                32'h0000_00FF << (8 * k));
        end
        rdc(SRAM_BASE + 32'h0000_0012, SZ_HALF, 32'h1122_3344, 1,
            32'hFFFF_0000);
        // SRAM mirrored at the bottom of the map.
        @(posedge sys_clk_i);
        remap_sram_i <= 1'b1;
        rdc(32'h0000_0010, SZ_WORD, 32'h1122_3344, 1);
        wr(32'h0000_0020, SZ_WORD, 32'hCAFE_0001, 1);
        rdc(SRAM_BASE + 32'h0000_0020, SZ_WORD, 32'hCAFE_0001, 1);
        rdc(32'h0000_4000, SZ_WORD, 32'h0000_0000, 1);
        @(posedge sys_clk_i);
        remap_sram_i <= 1'b0;
        // Random words across SRAM, the last word first.
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            ra = SRAM_BASE + (seed & 32'h0000_1FFC);
            if (k == 0) begin
                ra = SRAM_BASE + SRAM_BYTES - 32'h0000_0004;
            end
            seed = xs(seed);
            wr(ra, SZ_WORD, seed, 1);
            rdc(ra, SZ_WORD, seed, 1);
        end
        // Flash halfwords into a word, direct and mirrored.
        wr(FLASH_BASE + 32'h0000_0200, SZ_HALF, 32'h0000_A5A5, 8);
        wr(FLASH_BASE + 32'h0000_0202, SZ_HALF, 32'h5A5A_0000, 8);
        rdc(FLASH_BASE + 32'h0000_0200, SZ_WORD, 32'h5A5A_A5A5, 15);
        rdc(FLASH_BASE + 32'h0000_0202, SZ_HALF, 32'h5A5A_5A5A, 8);
        rdc(FLASH_BASE + 32'h0000_0201, SZ_BYTE, 32'hA5A5_A5A5, 8,
            32'h0000_FF00);
        rdc(32'h0000_0200, SZ_WORD, 32'h5A5A_A5A5, 15);
        // The boot page stays hidden, direct and mirrored.
        wr(FLASH_BASE + 32'h0000_F800, SZ_HALF, 32'h0000_1234, 1);
        rdc(FLASH_BASE + 32'h0000_F800, SZ_WORD, 32'h0000_0000, 1);
        rdc(32'h0000_FFFC, SZ_WORD, 32'h0000_0000, 1);
        // Each fast bus window: top word, byte lane.
        for (int k = 0; k < 3; k++) begin
            ra = (k == 0) ? SB_GPIO_BASE : (k == 1) ? SB_FLCTL_BASE
                                                    : SB_PWM_BASE;
            rdc(ra + 32'h0000_03FC, SZ_WORD,
                (ra + 32'h0000_03FC) ^ 32'h5A5A_0000, 2);
            wr(ra + 32'h0000_0001, SZ_BYTE, 32'h0000_7700, 2);
        end
        // Peripheral bus read and write.
        rdc(PB_BASE + 32'h0000_0FFC, SZ_WORD,
            (PB_BASE + 32'h0000_0FFC) ^ 32'hC3C3_0000, 3);
        wr(PB_BASE + 32'h0000_0042, SZ_HALF, 32'hBEEF_0000, 3);
        // Unoccupied places answer zero.
        for (int k = 0; k < 4; k++) begin
            wr(hole[k], SZ_WORD, 32'hFFFF_FFFF, 1);
            rdc(hole[k], SZ_WORD, 32'h0000_0000, 1);
        end
        repeat (2) @(posedge sys_clk_i);
        check(32'(exp_d.size()), 32'h0000_0000);
        end_of_test();
    end
endmodule : test_memory_map_bus_decode
